// >>> smcr_cs_route.sv
// chip select decode and routing of selects to dram and nand logic
`timescale 1ns/1ps
module smcr_cs_route
  import smcr_pkg::*;
#(
  parameter int NUM_CS = 8
)
(
  // access
  input wire logic active,
  input wire logic [2:0] cs_idx,
  // routing
  input wire logic cs1_dram_route,
  input wire logic cs3_nand_enable,
  // results
  output logic [NUM_CS-1:0] cs_n,
  output logic nand_sel
);
  initial
  begin
    if (NUM_CS != 8)
      $error("smcr_cs_route serves exactly eight chip selects");
  end

  always_comb
  begin
    cs_n = '1;
    nand_sel = 1'b0;
    if (active)
    begin
      cs_n[cs_idx] = 1'b0;
      if (cs_idx == 3'd1 && cs1_dram_route)
        cs_n[1] = 1'b1;
      nand_sel = cs3_nand_enable && cs_idx == 3'd3;
    end
  end
endmodule

// >>> smcr_lane_mux.sv
// shared strobe and byte select pin functions
`timescale 1ns/1ps
module smcr_lane_mux
  import smcr_pkg::*;
(
  // access
  input wire logic active,
  input wire logic strobe,
  input wire logic write,
  input wire logic addr0,
  input wire logic [1:0] be,
  // configuration
  input wire logic wide,
  input wire logic byte_select,
  // pins
  output logic a0_lb_n,
  output logic rd_n,
  output logic wr0_we_n,
  output logic wr1_ub_n
);
  always_comb
  begin
    rd_n = ~(active && strobe && !write);
    a0_lb_n = addr0;
    wr0_we_n = ~(active && strobe && write);
    wr1_ub_n = 1'b1;
    if (wide)
    begin
      if (byte_select)
      begin
        a0_lb_n = ~(active && be[0]);
        wr1_ub_n = ~(active && be[1]);
      end
      else
      begin
        a0_lb_n = 1'b0;
        wr0_we_n = ~(active && strobe && write && be[0]);
        wr1_ub_n = ~(active && strobe && write && be[1]);
      end
    end
  end
endmodule

// >>> smcr_map.svh
// register offsets, field positions and reset values of the static memory front end
`ifndef SMCR_MAP_SVH
`define SMCR_MAP_SVH
`define SMCR_CSA_OFF 8'h00
`define SMCR_RSV_A_OFF 8'h04
`define SMCR_RSV_B_OFF 8'h08
`define SMCR_RSV_C_OFF 8'h0c
`define SMCR_CFG_BASE 8'h40
`define SMCR_STAT_OFF 8'h60
`define SMCR_CSA_RST 32'h0000_0000
`define SMCR_CSA_MASK 32'h0001_001e
`define SMCR_CS1_BIT 1
`define SMCR_CS2_BIT 2
`define SMCR_CS3_BIT 3
`define SMCR_CS4_BIT 4
`define SMCR_WAITC_BIT 16
`define SMCR_CFG_RST 7'h01
`define SMCR_CFG_W_LSB 0
`define SMCR_CFG_BAT_BIT 2
`define SMCR_CFG_NWS_LSB 3
`define SMCR_W8 2'b10
`define SMCR_W16 2'b01
`define SMCR_PAGE_LSB 23
`define SMCR_ALE_BIT 21
`define SMCR_CLE_BIT 22
`endif

// >>> smcr_mem_model.sv
// behavioural static memory and wait source on the far side of the front end
`timescale 1ns/1ps
module smcr_mem_model
(
  // clock
  input wire logic sys_clk,
  // memory pins
  input wire logic [7:0] cs_n,
  input wire logic [22:1] addr_hi,
  input wire logic a0,
  input wire logic rd_n,
  input wire logic wr0_n,
  input wire logic wr1_n,
  input wire logic [15:0] dout,
  output logic [15:0] din,
  output logic wait_n,
  // wait length
  input wire logic [3:0] stall
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  logic [3:0] cnt = 4'h0;
  logic [2:0] idx;
  logic strb_q = 1'b0;
  logic strb;
  assign strb = !rd_n || !wr0_n || !wr1_n;
  always_comb
  begin
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (!cs_n[i])
        idx = 3'(i);
  end
  // small memory: upper address bits ignored, so it repeats through the page
  always @(posedge sys_clk)
  begin
    if (!(&cs_n) && !wr0_n)
      mem[{idx, addr_hi[4:1], a0}][7:0] <= dout[7:0];
    if (!(&cs_n) && !wr1_n)
      mem[{idx, addr_hi[4:1], a0}][15:8] <= dout[15:8];
    last <= din;
    strb_q <= strb;
    cnt <= (strb && !strb_q) ? stall : ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0);
  end
  // released bus shows the inverse of its last value
  assign din = (!(&cs_n) && !rd_n) ? mem[{idx, addr_hi[4:1], a0}] : ~last;
  // wait held low for stall cycles from the first clock edge inside a strobe
  assign wait_n = (cnt == 4'h0);
endmodule

// >>> smcr_pkg.sv
// types shared by the static memory front end
package smcr_pkg;
  typedef enum logic [1:0] {
    SMCR_IDLE = 2'b00,
    SMCR_SETUP = 2'b01,
    SMCR_STROBE = 2'b11,
    SMCR_HOLD = 2'b10
  } smcr_state_t;
endpackage

// >>> smcr_static_mem.sv
// static memory controller front end with chip select assignment register
//
// Functional notes
// - csa bit 1 set hands chip select 1 to the dram controller.
// - csa bit 2 set enables second card slot logic; select 2 stays static.
// - csa bit 3 set enables nand logic on select 3.
// - csa bit 4 set enables first card slot logic; select 4 stays static.
// - csa bit 16 connects the wait pin; clear leaves it free for gpio.
// - assignment register is read/write at offset zero, resets to zero.
// - eight active-low chip select outputs.
// - 23-bit address bus and 16-bit two-way data bus.
// - per-select width code: 10 gives 8 bits, 01 gives 16 bits.
// - 8-bit uses address bits 22..0, 16-bit uses bits 22..1.
// - small memories repeat through the page; upper bits ignored.
// - each select decodes at most 8 Mbytes.
// - shared pin is address bit 0 or lower byte select by width.
// - write pins are byte strobes or enable plus upper select.
// - separate active-low read and write strobes.
// - active-low wait input lengthens the strobe.
// - nand latch enables follow address bits 21 and 22.
// - nand strobes follow controller strobes only inside select 3.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "smcr_map.svh"
module smcr_static_mem
  import smcr_pkg::*;
#(
  parameter int NUM_CS = 8,
  parameter int ADDR_W = 23,
  parameter int DATA_W = 16
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // access requests
  input wire logic req_valid,
  input wire logic [25:0] req_addr,
  input wire logic req_write,
  input wire logic [15:0] req_wdata,
  input wire logic [1:0] req_be,
  output logic req_ack,
  output logic [15:0] req_rdata,
  // memory pins
  output logic [7:0] chip_select_lines_n,
  output logic [22:1] addr_hi,
  output logic addr0_or_lower_byte_n,
  output logic read_strobe_n,
  output logic write_low_or_write_enable_n,
  output logic write_high_or_upper_byte_n,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_n,
  input wire logic wait_n,
  // nand, card slot and routing status
  output logic nand_read_enable_n,
  output logic nand_write_enable_n,
  output logic nand_ale,
  output logic nand_cle,
  output logic cs1_dram_route,
  output logic card_slot1_active,
  output logic card_slot2_active,
  output logic wait_pin_gpio_free
);
  initial
  begin
    if (NUM_CS != 8 || ADDR_W != 23 || DATA_W != 16)
      $error("smcr_static_mem serves 8 selects, 23 address and 16 data bits");
  end

  // ----------------------------------------
  // apb register file
  // ----------------------------------------
  logic [31:0] csa_r;
  logic [6:0] cfg_r [NUM_CS];
  smcr_state_t state_r;
  logic [3:0] cnt_r;
  logic setup_ph;
  logic wr_en;
  logic is_cfg;
  logic [2:0] cfg_idx;
  logic hit;
  logic [31:0] rd_val;

  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign is_cfg = paddr[7:5] == 3'(`SMCR_CFG_BASE >> 5) && paddr[1:0] == 2'b00;
  assign cfg_idx = paddr[4:2];

  always_comb
  begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (is_cfg)
      rd_val = {25'h0000000, cfg_r[cfg_idx]};
    else
      case (paddr)
        `SMCR_CSA_OFF: rd_val = csa_r;
        `SMCR_RSV_A_OFF, `SMCR_RSV_B_OFF, `SMCR_RSV_C_OFF: rd_val = 32'h0000_0000;
        `SMCR_STAT_OFF: rd_val = {28'h0000000, cnt_r == 4'h0, state_r, req_ack};
        default: hit = 1'b0;
      endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph && !hit;
      prdata <= (setup_ph && hit && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      csa_r <= `SMCR_CSA_RST;
    else if (wr_en && paddr == `SMCR_CSA_OFF)
      csa_r <= pwdata & `SMCR_CSA_MASK;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CS; i++)
        cfg_r[i] <= `SMCR_CFG_RST;
    end
    else if (wr_en && is_cfg)
      cfg_r[cfg_idx] <= pwdata[6:0];
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  logic [25:0] lat_addr;
  logic lat_write;
  logic [15:0] lat_wdata;
  logic [1:0] lat_be;
  logic [2:0] cs_idx;
  logic [6:0] cur_cfg;
  logic wide;
  logic wait_hold;

  assign cs_idx = lat_addr[25:`SMCR_PAGE_LSB];
  assign cur_cfg = cfg_r[cs_idx];
  assign wide = cur_cfg[`SMCR_CFG_W_LSB +: 2] != `SMCR_W8;
  assign wait_hold = csa_r[`SMCR_WAITC_BIT] && !wait_n;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lat_addr <= 26'h0000000;
      lat_write <= 1'b0;
      lat_wdata <= 16'h0000;
      lat_be <= 2'b00;
    end
    else if (state_r == SMCR_IDLE && req_valid && !req_ack)
    begin
      lat_addr <= req_addr;
      lat_write <= req_write;
      lat_wdata <= req_wdata;
      lat_be <= req_be;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= SMCR_IDLE;
      cnt_r <= 4'h0;
    end
    else
    begin
      case (state_r)
        SMCR_IDLE:
          if (req_valid && !req_ack)
            state_r <= SMCR_SETUP;
        SMCR_SETUP:
        begin
          state_r <= SMCR_STROBE;
          cnt_r <= cur_cfg[`SMCR_CFG_NWS_LSB +: 4];
        end
        SMCR_STROBE:
          if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
          else if (!wait_hold)
            state_r <= SMCR_HOLD;
        SMCR_HOLD:
          state_r <= SMCR_IDLE;
        default:
          state_r <= SMCR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      req_ack <= 1'b0;
      req_rdata <= 16'h0000;
    end
    else
    begin
      req_ack <= state_r == SMCR_HOLD;
      // read pin lags the state by one cycle: take the data in hold
      if (state_r == SMCR_HOLD && !lat_write)
        req_rdata <= wide ? data_in : {8'h00, data_in[7:0]};
    end
  end

  // ----------------------------------------
  // pin generation
  // ----------------------------------------
  logic active;
  logic strobe;
  logic [7:0] cs_n_c;
  logic nand_sel;
  logic a0_c;
  logic rd_c;
  logic wr0_c;
  logic wr1_c;

  assign active = state_r != SMCR_IDLE;
  assign strobe = state_r == SMCR_STROBE;

  smcr_cs_route #(.NUM_CS(NUM_CS)) u_route (
    .active(active),
    .cs_idx(cs_idx),
    .cs1_dram_route(csa_r[`SMCR_CS1_BIT]),
    .cs3_nand_enable(csa_r[`SMCR_CS3_BIT]),
    .cs_n(cs_n_c),
    .nand_sel(nand_sel)
  );

  smcr_lane_mux u_lane (
    .active(active),
    .strobe(strobe),
    .write(lat_write),
    .addr0(lat_addr[0]),
    .be(lat_be),
    .wide(wide),
    .byte_select(cur_cfg[`SMCR_CFG_BAT_BIT]),
    .a0_lb_n(a0_c),
    .rd_n(rd_c),
    .wr0_we_n(wr0_c),
    .wr1_ub_n(wr1_c)
  );

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      chip_select_lines_n <= 8'hff;
      addr_hi <= 22'h000000;
      addr0_or_lower_byte_n <= 1'b0;
      read_strobe_n <= 1'b1;
      write_low_or_write_enable_n <= 1'b1;
      write_high_or_upper_byte_n <= 1'b1;
      data_out <= 16'h0000;
      data_oe_n <= 1'b1;
    end
    else
    begin
      chip_select_lines_n <= cs_n_c;
      addr_hi <= lat_addr[22:1];
      addr0_or_lower_byte_n <= a0_c;
      read_strobe_n <= rd_c;
      write_low_or_write_enable_n <= wr0_c;
      write_high_or_upper_byte_n <= wr1_c;
      data_out <= wide ? lat_wdata : {8'h00, lat_wdata[7:0]};
      data_oe_n <= !(active && lat_write);
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      nand_read_enable_n <= 1'b1;
      nand_write_enable_n <= 1'b1;
      nand_ale <= 1'b0;
      nand_cle <= 1'b0;
    end
    else
    begin
      nand_read_enable_n <= !(nand_sel && !rd_c);
      nand_write_enable_n <= !(nand_sel && !wr0_c);
      nand_ale <= nand_sel && lat_addr[`SMCR_ALE_BIT];
      nand_cle <= nand_sel && lat_addr[`SMCR_CLE_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cs1_dram_route <= 1'b0;
      card_slot1_active <= 1'b0;
      card_slot2_active <= 1'b0;
      wait_pin_gpio_free <= 1'b1;
    end
    else
    begin
      cs1_dram_route <= csa_r[`SMCR_CS1_BIT];
      card_slot2_active <= csa_r[`SMCR_CS2_BIT];
      card_slot1_active <= csa_r[`SMCR_CS4_BIT];
      wait_pin_gpio_free <= !csa_r[`SMCR_WAITC_BIT];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  cs1_route_a: assert property ($past(csa_r[1]) |-> chip_select_lines_n[1])
    else $error("select 1 driven while routed to dram");
  slot_flags_a: assert property (card_slot2_active == $past(csa_r[2])
    && card_slot1_active == $past(csa_r[4]))
    else $error("card slot flag does not follow csa");
  nand_off_a: assert property (!$past(csa_r[3]) |-> nand_read_enable_n
    && nand_write_enable_n && !nand_ale && !nand_cle)
    else $error("nand pins move with nand logic off");
  wait_ignore_a: assert property (state_r == SMCR_STROBE && cnt_r == 4'h0
    && !csa_r[16] |=> state_r == SMCR_HOLD)
    else $error("wait honoured while pin disconnected");
  csa_write_a: assert property (wr_en && paddr == 8'h00
    |=> csa_r == ($past(pwdata) & 32'h0001_001e))
    else $error("csa write not stored or unused bits kept");
  one_select_a: assert property ($countones(~chip_select_lines_n) <= 1)
    else $error("more than one chip select low");
  wait_stretch_a: assert property (state_r == SMCR_STROBE && cnt_r == 4'h0
    && wait_hold |=> state_r == SMCR_STROBE)
    else $error("strobe ended during external wait");
  narrow_a0_a: assert property ($past(active) && !$past(wide)
    |-> addr0_or_lower_byte_n == $past(lat_addr[0]))
    else $error("address bit 0 wrong on 8-bit select");
  nand_follow_a: assert property (!$past(nand_sel)
    |-> nand_read_enable_n && nand_write_enable_n)
    else $error("nand strobe outside select 3");
  apb_answer_a: assert property (setup_ph |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

  write_cyc_c: cover property (state_r == SMCR_STROBE && lat_write ##[1:40] req_ack);
  read_cyc_c: cover property (state_r == SMCR_HOLD && !lat_write);
  nand_cyc_c: cover property (!nand_write_enable_n);
  wait_cyc_c: cover property (state_r == SMCR_STROBE && cnt_r == 4'h0 && wait_hold);
endmodule

// >>> static_mem_cs_routing_tb.sv
// self-checking bench of the static memory front end
`timescale 1ns/1ps
`include "smcr_map.svh"
module static_mem_cs_routing_tb;
  import smcr_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, req_valid, req_write, req_ack;
  logic [7:0] paddr, cs_n;
  logic [31:0] pwdata, prdata, rd;
  logic [25:0] req_addr;
  logic [15:0] req_wdata, req_rdata, din, dout, rv;
  logic [1:0] req_be;
  logic [22:1] ahi;
  logic a0, rd_n, wr0_n, wr1_n, oe_n, wait_n, nre_n, nwe_n, ale, cle, dram, cf1, cf2, gfree;
  logic sa0, sub, soe, err;
  logic [9:0] mon_and;
  logic [1:0] mon_or;
  logic [3:0] stall;
  int fails, n_compared, lat, base;

  smcr_static_mem i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
    .req_wdata(req_wdata), .req_be(req_be), .req_ack(req_ack), .req_rdata(req_rdata),
    .chip_select_lines_n(cs_n), .addr_hi(ahi), .addr0_or_lower_byte_n(a0),
    .read_strobe_n(rd_n), .write_low_or_write_enable_n(wr0_n),
    .write_high_or_upper_byte_n(wr1_n), .data_in(din), .data_out(dout), .data_oe_n(oe_n),
    .wait_n(wait_n), .nand_read_enable_n(nre_n), .nand_write_enable_n(nwe_n),
    .nand_ale(ale), .nand_cle(cle), .cs1_dram_route(dram), .card_slot1_active(cf1),
    .card_slot2_active(cf2), .wait_pin_gpio_free(gfree));

  // pins wired straight to the model: pin mux taken as set for the bus
  smcr_mem_model i_mem (.sys_clk(sys_clk), .cs_n(cs_n), .addr_hi(ahi), .a0(a0),
    .rd_n(rd_n), .wr0_n(wr0_n), .wr1_n(wr1_n), .dout(dout), .din(din), .wait_n(wait_n),
    .stall(stall));

  // -----------------------------------------
  // clock and access monitor
  // -----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (req_valid)
    begin
      mon_and <= mon_and & {cs_n, nre_n, nwe_n};
      mon_or <= mon_or | {ale, cle};
      if (!rd_n)
      begin
        sa0 <= a0;
        sub <= wr1_n;
      end
      if (!wr0_n)
        soe <= oe_n;
    end

  // -----------------------------------------
  // tasks
  // -----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, 32'h0);
    chk("prdata", rd, x);
    chk("pslverr", err, e);
  endtask

  task automatic acc(input logic [25:0] a, input logic w, input logic [15:0] wd,
    input logic [1:0] be);
    int n;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_write <= w;
    req_wdata <= wd;
    req_be <= be;
    mon_and <= '1;
    mon_or <= '0;
    soe <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (req_ack !== 1'b1);
    rv = req_rdata;
    lat = n;
    req_valid <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // -----------------------------------------
  // tests
  // -----------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, req_valid, req_addr} = '0;
    {req_write, req_wdata, req_be, stall, fails, n_compared} = '0;
    rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("gpio_free", gfree, 1'b1);
    chk("cs_idle", cs_n, 8'hff);
    rchk(`SMCR_CSA_OFF, `SMCR_CSA_RST, 1'b0);
    rchk(`SMCR_CFG_BASE, `SMCR_CFG_RST, 1'b0);
    for (int i = 1; i < 4; i++)
      rchk(8'(4 * i), 32'h0, 1'b0);
    rchk(8'h20, 32'h0, 1'b1);
    apb(1'b1, `SMCR_CSA_OFF, 32'hffff_ffff);
    rchk(`SMCR_CSA_OFF, `SMCR_CSA_MASK, 1'b0);
    chk("routes", {dram, cf1, cf2, gfree}, 4'b1110);
    // select 1 left high while it is routed to the dram controller
    acc({3'd1, 23'h10}, 1'b0, 16'h0, 2'b11);
    chk("cs1_held", mon_and[9:2], 8'hff);
    acc({3'd3, 23'h20_0000}, 1'b0, 16'h0, 2'b11);
    chk("nand_ale", {mon_or, mon_and[1]}, 3'b100);
    acc({3'd3, 23'h40_0000}, 1'b1, 16'h0, 2'b11);
    chk("nand_cle", {mon_or, mon_and[0]}, 3'b010);
    acc({3'd0, 23'h20_0000}, 1'b0, 16'h0, 2'b11);
    chk("nand_off", {mon_and, mon_or}, 12'hfec);
    apb(1'b1, `SMCR_CFG_BASE, 32'h19);
    acc({3'd0, 23'h10}, 1'b0, 16'h0, 2'b11);
    base = lat;
    stall = 4'h6;
    acc({3'd0, 23'h10}, 1'b0, 16'h0, 2'b11);
    chk("wait_on", lat > base, 1'b1);
    apb(1'b1, `SMCR_CSA_OFF, 32'h0);
    acc({3'd0, 23'h10}, 1'b0, 16'h0, 2'b11);
    chk("wait_off", lat, base);
    stall = 4'h0;
    acc({3'd0, 23'h10}, 1'b1, 16'ha55a, 2'b11);
    chk("oe_wr", soe, 1'b0);
    acc({3'd0, 23'h10}, 1'b1, 16'hffff, 2'b01);
    acc({3'd0, 23'h40_0010}, 1'b0, 16'h0, 2'b11);
    chk("rd16_wrap", rv, 16'ha5ff);
    apb(1'b1, 8'(`SMCR_CFG_BASE + 8), 32'h2);
    acc({3'd2, 23'h1}, 1'b1, 16'h003c, 2'b01);
    acc({3'd2, 23'h0}, 1'b1, 16'h00c3, 2'b01);
    acc({3'd2, 23'h1}, 1'b0, 16'h0, 2'b01);
    chk("rd8", {sa0, rv[7:0]}, 9'h13c);
    apb(1'b1, `SMCR_CFG_BASE, 32'h1d);
    acc({3'd0, 23'h10}, 1'b0, 16'h0, 2'b10);
    chk("byte_sel", {sa0, sub}, 2'b10);
    give_verdict();
  end

  initial
  begin
    #100us;
    fails++;
    give_verdict();
  end
endmodule
